// ---- pkg/irq_defs.svh ----
// register map, field positions, masks and reset values of the interrupt
// controller; included by the package and by every design file
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH

// register word indexes, byte address = index * 4
`define IDX_EDGE_SEL   3'h0
`define IDX_CTRL0      3'h1
`define IDX_CTRL1      3'h2
`define IDX_CTRL2      3'h3
`define IDX_GROUP0     3'h4
`define IDX_GROUP1     3'h5
`define IDX_GROUP2     3'h6
`define IDX_GROUP3     3'h7
`define NUM_REGS       8
`define ADDR_W         12
`define ADDR_TOP       11
`define IDX_LSB        2
`define IDX_MSB        4
`define MAP_TOP_LSB    5

`define REG_RESET      8'h00
// writable bits and hardware-set flag bits per register
`define RW_EDGE_SEL    8'h0f
`define RW_CTRL0       8'h7f
`define RW_CTRL1       8'hff
`define RW_CTRL2       8'h33
`define RW_GROUP       8'hff
`define RW_GROUP3      8'h33
`define FL_NONE        8'h00
`define FL_CTRL0       8'h70
`define FL_FULL        8'hf0
`define FL_HALF        8'h30

// field positions
`define EDGE0_LSB      0
`define EDGE1_LSB      2
`define GLOBAL_EN_BIT  0
`define PIN0_EN_BIT    1
`define PIN1_EN_BIT    2
`define ADC_EN_BIT     3
`define PIN0_FLAG_BIT  4
`define PIN1_FLAG_BIT  5
`define ADC_FLAG_BIT   6
`define FLAG_LSB       4

// primary sources, in falling priority
`define SRC_PIN0       4'h0
`define SRC_PIN1       4'h1
`define SRC_ADC        4'h2
`define SRC_GROUP0     4'h3
`define SRC_TB0        4'h7
`define SRC_TB1        4'h8
`define NUM_SRC        9
`define NUM_GROUPS     4

`endif

// ---- pkg/irq_pkg.sv ----
// types shared by the interrupt controller files
`include "irq_defs.svh"

package irq_pkg;
  typedef logic [7:0] reg8_t;
  typedef logic [3:0] src_idx_t;
  typedef logic [`ADDR_W-1:0] addr_t;
  // order gives the two-bit field codes 00, 01, 10, 11
  typedef enum logic [1:0] {
    EDGE_OFF,
    EDGE_RISE,
    EDGE_FALL,
    EDGE_BOTH
  } edge_mode_e;
endpackage

// ---- hdl/pin_edge_sense.sv ----
// synchroniser and edge detector for one external interrupt pin
// assumes pin is asynchronous to pclk; pulse is one pclk cycle
`timescale 1ns/1ps
`include "irq_defs.svh"

module pin_edge_sense (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               pin,
  input  wire irq_pkg::edge_mode_e mode,
  output logic                    edge_pulse
);
  import irq_pkg::*;

  logic meta_r;
  logic sync_r;
  logic last_r;
  wire  rise = sync_r & ~last_r;
  wire  fall = ~sync_r & last_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  always_comb begin
    case (mode)
      EDGE_OFF:  edge_pulse = 1'b0;
      EDGE_RISE: edge_pulse = rise;
      EDGE_FALL: edge_pulse = fall;
      EDGE_BOTH: edge_pulse = rise | fall;
      default:   edge_pulse = 1'b0;
    endcase
  end
endmodule

// ---- hdl/irq_ctrl_reg.sv ----
// one 8-bit control register with software-writable bits and
// hardware-set flags; a set in the same cycle as a clear wins
`timescale 1ns/1ps
`include "irq_defs.svh"

module irq_ctrl_reg #(
  parameter logic [7:0] RW_MASK   = `RW_GROUP,
  parameter logic [7:0] FLAG_MASK = `FL_NONE
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           wr_en,
  input  wire irq_pkg::reg8_t wr_data,
  input  wire irq_pkg::reg8_t set_bits,
  input  wire irq_pkg::reg8_t clr_bits,
  output irq_pkg::reg8_t      q
);
  import irq_pkg::*;

  reg8_t q_r;
  reg8_t q_nxt;
  wire reg8_t written = wr_en ? wr_data : q_r;

  assign q_nxt = ((written & ~clr_bits) | (set_bits & FLAG_MASK)) & RW_MASK;
  assign q     = q_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) q_r <= `REG_RESET;
    else          q_r <= q_nxt;
  end
endmodule

// ---- hdl/mcu_interrupt_control.sv ----
// interrupt controller: request flags, enables, multi-function groups,
// edge selection for two external pins, and a pin-change input fixed to both edges
// assumes an APB master on pclk; peripheral requests are one-cycle pulses
// on pclk; external pins are asynchronous
//
// Overview of operation
// (R1) a source's trigger sets its flag; enables change only by software; the code also clears the global enable when the core accepts a request
// (R2) an accepted request raises the core request and suspends the program
// (R3) two interrupt pins and one pin-change input, each enable plus flag
// (R4) timer, time base, low voltage, serial, uart, converter each own bits
// (R5) pin one edge field bits 3..2: off, rising, falling, both
// (R6) pin zero edge field bits 1..0 with the same four codes
// (R7) edge register bits 7..4 read zero and ignore writes
// (R8) pin zero flag at control register 0 bit 4, one when pending
// (R9) pin one enable at control register 0 bit 2
// (R10) pin zero enable at control register 0 bit 1
// (R11) three primary control registers hold global, pin, converter, group
// (R12) four group registers; each group raises one request, enable and flag
// (R13) request needs flag, own enable, global enable, group enable if grouped
// (R14) flags read and write, software clears by zero; all reset to zero
`timescale 1ns/1ps
`include "irq_defs.svh"

module mcu_interrupt_control (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire irq_pkg::addr_t paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          ext_pin_zero,
  input  wire logic          ext_pin_one,
  input  wire logic          port_change_input,
  input  wire logic          adc_req,
  input  wire logic [1:0]    time_base_req,
  input  wire logic [3:0]    tm_period_req,
  input  wire logic [3:0]    tm_match_a_req,
  input  wire logic          tm1_match_b_req,
  input  wire logic          sync_serial_req,
  input  wire logic          spi1_req,
  input  wire logic          uart_req,
  input  wire logic          low_voltage_req,
  input  wire logic          irq_ack,
  output logic               irq_req,
  output irq_pkg::src_idx_t  irq_vector
);
  import irq_pkg::*;

  // every check below runs on pclk and sleeps while reset is low
  default clocking chk_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  localparam reg8_t RW_MASKS [`NUM_REGS] = '{`RW_EDGE_SEL, `RW_CTRL0,
    `RW_CTRL1, `RW_CTRL2, `RW_GROUP, `RW_GROUP, `RW_GROUP, `RW_GROUP3};
  localparam reg8_t FL_MASKS [`NUM_REGS] = '{`FL_NONE, `FL_CTRL0,
    `FL_FULL, `FL_HALF, `FL_FULL, `FL_FULL, `FL_FULL, `FL_HALF};

  // apb slave: answer in the first access cycle
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic        irq_req_r;
  src_idx_t    irq_vector_r;

  reg8_t regs [`NUM_REGS];
  reg8_t set_v [`NUM_REGS];
  reg8_t clr_v [`NUM_REGS];

  wire [2:0] reg_idx  = paddr[`IDX_MSB:`IDX_LSB];
  wire       mapped   = (paddr[`ADDR_TOP:`MAP_TOP_LSB] == '0) &&
                        (paddr[`IDX_LSB-1:0] == '0);
  wire       setup    = psel & ~penable & ~pready_r;
  wire       done     = psel & penable & pready_r;
  wire       wr_take  = done & pwrite & mapped;
  wire reg8_t rd_sel  = regs[reg_idx];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~mapped;
      prdata_r  <= (setup & ~pwrite & mapped) ? {24'h000000, rd_sel} : '0;
    end
  end

  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

  // external pins and pin-change input
  wire reg8_t edge_reg = regs[`IDX_EDGE_SEL];
  wire reg8_t ctrl0    = regs[`IDX_CTRL0];
  wire reg8_t ctrl1    = regs[`IDX_CTRL1];
  wire reg8_t ctrl2    = regs[`IDX_CTRL2];
  logic pin0_edge;
  logic pin1_edge;
  logic port_edge;

  pin_edge_sense u_pin0 (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin        (ext_pin_zero),
    .mode       (edge_mode_e'(edge_reg[`EDGE0_LSB +: 2])), // R6
    .edge_pulse (pin0_edge)
  );

  pin_edge_sense u_pin1 (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin        (ext_pin_one),
    .mode       (edge_mode_e'(edge_reg[`EDGE1_LSB +: 2])), // R5
    .edge_pulse (pin1_edge)
  );

  // any change on the port input counts
  pin_edge_sense u_port (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin        (port_change_input),
    .mode       (EDGE_BOTH), // R3
    .edge_pulse (port_edge)
  );

  // group request: any group flag whose own enable is set
  logic [`NUM_GROUPS-1:0] group_hit;
  genvar g;
  generate
    for (g = 0; g < `NUM_GROUPS; g++) begin : g_group
      assign group_hit[g] = |(regs[`IDX_GROUP0 + g][7:`FLAG_LSB] &
                              regs[`IDX_GROUP0 + g][`FLAG_LSB-1:0]); // R12
    end
  endgenerate

  // hardware set vectors, flags sit in bits 7..4
  assign set_v[`IDX_EDGE_SEL] = '0;
  assign set_v[`IDX_CTRL0]  = {1'b0, adc_req, pin1_edge, pin0_edge,
                               4'h0}; // R1 R3 R4 R8
  assign set_v[`IDX_CTRL1]  = {group_hit, 4'h0}; // R12
  assign set_v[`IDX_CTRL2]  = {2'b00, time_base_req, 4'h0}; // R4
  assign set_v[`IDX_GROUP0] = {tm_match_a_req[2], tm_period_req[2],
                               tm_match_a_req[0], tm_period_req[0], 4'h0};
  assign set_v[`IDX_GROUP1] = {uart_req, tm1_match_b_req,
                               tm_match_a_req[1], tm_period_req[1], 4'h0};
  assign set_v[`IDX_GROUP2] = {tm_match_a_req[3], tm_period_req[3],
                               port_edge, sync_serial_req, 4'h0};
  assign set_v[`IDX_GROUP3] = {2'b00, spi1_req, low_voltage_req, 4'h0};

  // pending primary sources with their own enables
  logic [`NUM_SRC-1:0] pend;
  assign pend[`SRC_PIN0] = ctrl0[`PIN0_FLAG_BIT] & ctrl0[`PIN0_EN_BIT]; // R10
  assign pend[`SRC_PIN1] = ctrl0[`PIN1_FLAG_BIT] & ctrl0[`PIN1_EN_BIT]; // R9
  assign pend[`SRC_ADC]  = ctrl0[`ADC_FLAG_BIT] & ctrl0[`ADC_EN_BIT];
  assign pend[`SRC_TB0]  = ctrl2[`FLAG_LSB] & ctrl2[0];
  assign pend[`SRC_TB1]  = ctrl2[`FLAG_LSB+1] & ctrl2[1];
  generate
    for (g = 0; g < `NUM_GROUPS; g++) begin : g_pend
      assign pend[`SRC_GROUP0 + g] = ctrl1[`FLAG_LSB + g] & ctrl1[g]; // R13
    end
  endgenerate

  wire global_en = ctrl0[`GLOBAL_EN_BIT];
  wire any_pend  = global_en & (|pend); // R13

  // lowest index pending wins
  function automatic src_idx_t first_src(input logic [`NUM_SRC-1:0] p);
    first_src = '0;
    for (int i = `NUM_SRC - 1; i >= 0; i--) begin
      if (p[i]) first_src = src_idx_t'(i);
    end
  endfunction

  // acceptance by the core clears the served flag and the global enable; a ctrl1 group flag stays set while its group_hit holds
  wire                ack_take = irq_ack & irq_req_r;
  wire [`NUM_SRC-1:0] ack_oh   = ack_take ?
                                 (`NUM_SRC'(1) << irq_vector_r) : '0;

  assign clr_v[`IDX_EDGE_SEL] = '0;
  assign clr_v[`IDX_CTRL0]  = {1'b0, ack_oh[`SRC_ADC], ack_oh[`SRC_PIN1],
                               ack_oh[`SRC_PIN0], 3'b000, ack_take}; // R2
  assign clr_v[`IDX_CTRL1]  = {ack_oh[`SRC_GROUP0 +: `NUM_GROUPS], 4'h0};
  assign clr_v[`IDX_CTRL2]  = {2'b00, ack_oh[`SRC_TB1], ack_oh[`SRC_TB0],
                               4'h0};
  generate
    for (g = `IDX_GROUP0; g < `NUM_REGS; g++) begin : g_clr
      assign clr_v[g] = '0;
    end
  endgenerate

  // register file; unimplemented bits stay zero
  genvar r;
  generate
    for (r = 0; r < `NUM_REGS; r++) begin : g_reg
      irq_ctrl_reg #(
        .RW_MASK   (RW_MASKS[r]), // R7 R11
        .FLAG_MASK (FL_MASKS[r])
      ) u_reg (
        .pclk     (pclk),
        .presetn  (presetn), // R14
        .wr_en    (wr_take && (reg_idx == r)), // R14
        .wr_data  (pwdata[7:0]),
        .set_bits (set_v[r]), // R1
        .clr_bits (clr_v[r]),
        .q        (regs[r])
      );
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_r    <= 1'b0;
      irq_vector_r <= '0;
    end else begin
      irq_req_r    <= any_pend & ~ack_take; // R2
      irq_vector_r <= first_src(pend);
    end
  end

  assign irq_req    = irq_req_r;
  assign irq_vector = irq_vector_r;

  // checks
  edge_upper_zero_a: assert property ( // R7
    edge_reg[7:4] == 4'h0)
    else $error("edge register upper bits not zero");

  apb_one_wait_a: assert property (
    setup |=> pready_r ##1 !pready_r)
    else $error("apb answer not in first access cycle");

  req_needs_global_a: assert property ( // R13
    irq_req_r |-> $past(global_en))
    else $error("request raised with global enable off");

  ack_drops_global_a: assert property ( // R2
    ack_take |=> !global_en && !irq_req_r)
    else $error("acceptance did not clear global enable");

  ack_clears_flag_a: assert property ( // R2
    (ack_take && irq_vector_r == `SRC_ADC) |=>
      !ctrl0[`ADC_FLAG_BIT] || $past(adc_req))
    else $error("acceptance did not clear the converter flag");

  pin0_flag_set_a: assert property ( // R8
    pin0_edge |=> ctrl0[`PIN0_FLAG_BIT])
    else $error("pin zero edge did not set its flag");

  pin1_flag_set_a: assert property ( // R5
    pin1_edge |=> ctrl0[`PIN1_FLAG_BIT])
    else $error("pin one edge did not set its flag");

  port_flag_set_a: assert property ( // R3
    port_edge |=> regs[`IDX_GROUP2][`FLAG_LSB+1])
    else $error("port change did not set its flag");

  time_base_set_a: assert property ( // R4
    |time_base_req |=> (ctrl2[`FLAG_LSB +: 2] & $past(time_base_req)) ==
      $past(time_base_req))
    else $error("time base request did not set its flag");

  set_beats_clear_a: assert property ( // R1
    adc_req |=> ctrl0[`ADC_FLAG_BIT])
    else $error("flag lost when set met a clear");

  pin_off_quiet_a: assert property ( // R5
    (edge_reg[`EDGE1_LSB +: 2] == 2'b00) |-> !pin1_edge)
    else $error("disabled pin produced an edge");

  pin0_off_quiet_a: assert property ( // R6
    (edge_reg[`EDGE0_LSB +: 2] == 2'b00) |-> !pin0_edge)
    else $error("disabled pin zero produced an edge");

  pin0_needs_en_a: assert property ( // R10
    (irq_req_r && irq_vector_r == `SRC_PIN0) |-> $past(ctrl0[`PIN0_EN_BIT]))
    else $error("pin zero request raised with its enable off");

  pin1_needs_en_a: assert property ( // R9
    (irq_req_r && irq_vector_r == `SRC_PIN1) |-> $past(ctrl0[`PIN1_EN_BIT]))
    else $error("pin one request raised with its enable off");

  group_raises_a: assert property ( // R12
    (group_hit[0] && !$past(ack_take)) |=> ctrl1[`FLAG_LSB])
    else $error("group request did not set its flag");

  write_stores_a: assert property ( // R10
    (wr_take && reg_idx == `IDX_CTRL0 && !ack_take) |=>
      ctrl0[3:0] == $past(pwdata[3:0]))
    else $error("enable write not stored");

  unmapped_err_a: assert property ( // R14
    (setup && !mapped) |=> pslverr_r && pready_r)
    else $error("unmapped access not refused");

  req_cover_c: cover property (
    irq_req_r ##[1:20] ack_take);
  port_cover_c: cover property (
    port_edge ##[1:5] ctrl1[`FLAG_LSB+2]);
  both_edge_c: cover property (
    edge_reg[`EDGE0_LSB +: 2] == 2'b11 && pin0_edge);
  tb_cover_c: cover property (
    irq_req_r && irq_vector_r == `SRC_TB1);
  unmapped_c: cover property (
    setup && !mapped);
endmodule

// ---- bench/irq_far_side.sv ----
// model of the peripherals, external pins and core around the controller
// assumes pclk drives all requests; the core acks ack_dly + 1 cycles after irq_req rises
`timescale 1ns/1ps

module irq_far_side (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       irq_req,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_dly,
  output logic            ext_pin_zero,
  output logic            ext_pin_one,
  output logic            port_change_input,
  output logic            adc_req,
  output logic [1:0]      time_base_req,
  output logic [3:0]      tm_period_req,
  output logic [3:0]      tm_match_a_req,
  output logic            tm1_match_b_req,
  output logic            sync_serial_req,
  output logic            spi1_req,
  output logic            uart_req,
  output logic            low_voltage_req,
  output logic            irq_ack
);
  logic [15:0] reqv = '0;
  logic [3:0]  cnt;

  initial begin
    ext_pin_zero = 1'b0;
    ext_pin_one = 1'b0;
    port_change_input = 1'b0;
  end
  // one bit per peripheral request line
  assign adc_req = reqv[0];
  assign time_base_req = reqv[2:1];
  assign tm_period_req = reqv[6:3];
  assign tm_match_a_req = reqv[10:7];
  assign tm1_match_b_req = reqv[11];
  assign sync_serial_req = reqv[12];
  assign spi1_req = reqv[13];
  assign uart_req = reqv[14];
  assign low_voltage_req = reqv[15];

  task automatic pulse(input int k);
    @(posedge pclk) reqv[k] <= 1'b1;
    @(posedge pclk) reqv <= '0;
  endtask

  task automatic set_pin(input int p, input logic v);
    @(posedge pclk);
    if (p == 0) ext_pin_zero <= v;
    else if (p == 1) ext_pin_one <= v;
    else port_change_input <= v;
  endtask

  // core accepts a pending request after a chosen delay
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      irq_ack <= 1'b0;
    end else if (irq_ack) begin
      irq_ack <= 1'b0;
      cnt <= '0;
    end else if (ack_en && irq_req) begin
      if (cnt >= ack_dly) irq_ack <= 1'b1;
      else cnt <= cnt + 4'h1;
    end else begin
      cnt <= '0;
    end
  end
endmodule

// ---- bench/tb.sv ----
// self-checking bench for the interrupt controller
// assumes a 10 MHz pclk and the far-side model for sources and core
`timescale 1ns/1ps

module tb;
  import irq_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, ack_en = 1'b0, irq_prev = 1'b0;
  addr_t paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32'had5b;
  logic pready, pslverr, p0, p1, pc, adc, tmb, ser, spi, ur, lv, ack;
  logic irq_req;
  logic [3:0] ack_dly = 4'h0, tmp, tma;
  logic [1:0] tbr;
  src_idx_t irq_vector;
  logic [32:0] rd_q[$], vec_q[$];
  logic [7:0] mask[8] = '{8'h0f, 8'h7f, 8'hff, 8'h33,
                          8'hff, 8'hff, 8'hff, 8'h33};
  logic [7:0] v;
  int errors = 0, checks_done = 0;
  int src[4] = '{3, 4, 12, 15};

  always #50 pclk = ~pclk;

  mcu_interrupt_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_pin_zero(p0), .ext_pin_one(p1), .port_change_input(pc),
    .adc_req(adc), .time_base_req(tbr), .tm_period_req(tmp),
    .tm_match_a_req(tma), .tm1_match_b_req(tmb), .sync_serial_req(ser),
    .spi1_req(spi), .uart_req(ur), .low_voltage_req(lv), .irq_ack(ack),
    .irq_req(irq_req), .irq_vector(irq_vector));

  irq_far_side u_src (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
    .ack_en(ack_en), .ack_dly(ack_dly), .ext_pin_zero(p0),
    .ext_pin_one(p1), .port_change_input(pc), .adc_req(adc),
    .time_base_req(tbr), .tm_period_req(tmp), .tm_match_a_req(tma),
    .tm1_match_b_req(tmb), .sync_serial_req(ser), .spi1_req(spi),
    .uart_req(ur), .low_voltage_req(lv), .irq_ack(ack));

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic apb(input logic w, input addr_t a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40) begin
      errors++;
      report_and_stop();
    end
  endtask

  task automatic rd(input addr_t a, input logic [7:0] e);
    rd_q.push_back({9'h0, 24'h0, e});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (irq_req !== 1'b0 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 60) begin
      errors++;
      report_and_stop();
    end
  endtask

  // watcher: each read answer, and each new core request while a vector is queued, takes a note
  always @(posedge pclk) begin
    irq_prev <= irq_req;
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, rd_q.pop_front());
    if (irq_req === 1'b1 && !irq_prev && vec_q.size() > 0)
      chk({29'h0, irq_vector}, vec_q.pop_front());
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(4 * i, 8'h00);
    rd_q.push_back({1'b1, 32'h0});
    apb(1'b0, 12'h020, 32'h0);
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      apb(1'b1, 4 * i, {24'h0, v});
      rd(4 * i, v & mask[i]);
      apb(1'b1, 4 * i, 32'h0);
    end
    $display("register test done");
    for (int p = 0; p < 2; p++)
      for (int m = 0; m < 4; m++) begin
        apb(1'b1, 12'h000, m << (2 * p));
        u_src.set_pin(p, 1'b1);
        repeat (6) @(posedge pclk);
        rd(12'h004, 8'(m[0]) << (4 + p));
        apb(1'b1, 12'h004, 32'h0);
        u_src.set_pin(p, 1'b0);
        repeat (6) @(posedge pclk);
        rd(12'h004, 8'(m[1]) << (4 + p));
        apb(1'b1, 12'h004, 32'h0);
      end
    $display("edge test done");
    apb(1'b1, 12'h004, 32'h8);
    u_src.pulse(0);
    repeat (4) @(posedge pclk);
    chk({32'h0, irq_req}, 33'h0);
    ack_dly <= 4'h5;
    ack_en <= 1'b1;
    vec_q.push_back(33'h2);
    apb(1'b1, 12'h004, 32'h49);
    repeat (3) @(posedge pclk);
    wait_idle();
    rd(12'h004, 8'h08);
    $display("converter test done");
    ack_dly <= 4'h0;
    for (int g = 0; g < 4; g++) begin
      apb(1'b1, 12'h010 + 4 * g, 32'h1);
      apb(1'b1, 12'h008, 32'h1 << g);
      apb(1'b1, 12'h004, 32'h1);
      vec_q.push_back(33'(3 + g));
      u_src.pulse(src[g]);
      repeat (4) @(posedge pclk);
      wait_idle();
      rd(12'h010 + 4 * g, 8'h11);
      rd(12'h004, 8'h00);
      apb(1'b1, 12'h010 + 4 * g, 32'h0);
      apb(1'b1, 12'h008, 32'h0);
    end
    $display("group test done");
    // port change input sits in group 2, time base 1 in ctrl2
    apb(1'b1, 12'h018, 32'h2);
    apb(1'b1, 12'h008, 32'h4);
    apb(1'b1, 12'h004, 32'h1);
    vec_q.push_back(33'h5);
    u_src.set_pin(2, 1'b1);
    repeat (8) @(posedge pclk);
    wait_idle();
    rd(12'h018, 8'h22);
    apb(1'b1, 12'h018, 32'h0);
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h00c, 32'h2);
    apb(1'b1, 12'h004, 32'h1);
    vec_q.push_back(33'h8);
    u_src.pulse(2);
    repeat (4) @(posedge pclk);
    wait_idle();
    rd(12'h00c, 8'h02);
    $display("port and time base test done");
    repeat (3) @(posedge pclk);
    if (rd_q.size() + vec_q.size() != 0) errors++;
    report_and_stop();
  end
endmodule
